// [logic/pfdec_pkg.sv]
// Constants, types and register map of the persistence feature decoder
package pfdec_pkg;
  localparam int NS_COUNT = 8;
  localparam int NS_BITS = 3;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_NSID = 8'h04;
  localparam logic [7:0] OFS_DW10 = 8'h08;
  localparam logic [7:0] OFS_DW11 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CPL_DW0 = 8'h14;
  localparam logic [7:0] OFS_RESV_CAP = 8'h18;
  localparam logic [7:0] OFS_PERSIST = 8'h1C;
  localparam logic [7:0] OFS_FMT_SEL = 8'h20;
  localparam logic [7:0] OFS_FMT_INFO = 8'h24;
  localparam logic [7:0] OFS_SEC_STATE = 8'h28;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [NS_COUNT-1:0] RST_RESV_CAP = 8'h0F;
  localparam logic [NS_COUNT-1:0] RST_PERSIST = 8'h00;
  // ---------------------------------------------------------------
  // Command fields
  // ---------------------------------------------------------------
  localparam logic [7:0] FID_RESV_PERSIST = 8'h83;
  localparam logic [31:0] NSID_BROADCAST = 32'hFFFFFFFF;
  localparam int FID_LSB = 0;
  localparam int SAVE_BIT = 31;
  localparam int PERSIST_BIT = 0;
  localparam int PERSIST_UPD_MASK_LSB = 8;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 12;
  localparam int PROT_TYPE_LSB = 5;
  localparam int PROT_FIRST_BIT = 8;
  localparam int ERASE_SEL_LSB = 9;
  localparam logic [2:0] ERASE_NONE = 3'h0;
  localparam logic [2:0] ERASE_USER = 3'h1;
  localparam logic [2:0] ERASE_CRYPTO = 3'h2;
  localparam logic [2:0] PROT_OFF = 3'h0;
  localparam logic [2:0] PROT_TYPE3 = 3'h3;
  // ---------------------------------------------------------------
  // Completion status
  // ---------------------------------------------------------------
  localparam logic [2:0] SCT_GENERIC = 3'h0;
  localparam logic [2:0] SCT_CMD_SPEC = 3'h1;
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
  localparam logic [7:0] SC_SEC_STATE = 8'h0C;
  localparam logic [7:0] SC_NOT_SAVEABLE = 8'h0D;
  localparam logic [7:0] SC_NOT_CHANGEABLE = 8'h0E;
  localparam logic [7:0] SC_NOT_NS_SPECIFIC = 8'h0F;

  typedef enum logic [1:0] {
    PFD_CMD_NONE = 2'b00,
    PFD_CMD_SET = 2'b01,
    PFD_CMD_GET = 2'b10,
    PFD_CMD_FORMAT = 2'b11
  } pfdec_cmd_t;

  typedef enum logic [0:0] {
    PFD_IDLE = 1'b0,
    PFD_EXEC = 1'b1
  } pfdec_st_t;

  typedef struct packed {
    pfdec_st_t st;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
    pfdec_cmd_t cmd;
    logic [31:0] nsid;
    logic [31:0] dw10;
    logic [31:0] dw11;
    logic done;
    logic [2:0] sct;
    logic [7:0] sc;
    logic [31:0] dw0;
    logic [NS_COUNT-1:0] cap;
    logic [NS_COUNT-1:0] persist;
    logic [NS_BITS-1:0] fmt_sel;
    logic [NS_COUNT-1:0][FMT_W-1:0] fmt;
    logic sec_bad;
    logic pl_s1;
    logic pl_s2;
    logic pl_d;
    logic cq_post;
    logic fmt_start;
    logic [NS_COUNT-1:0] fmt_mask;
    logic [2:0] erase_sel;
    logic [2:0] pi_type;
    logic pi_first;
    logic key_delete;
    logic [NS_COUNT-1:0] release_mask;
  } pfdec_state_t;
endpackage

// [logic/pfdec_core.sv]
// Persistence feature and format command decoder with AHB-Lite registers
//
// Functional notes
// RQ1 - Feature 83h, attributes in dword 11
// RQ2 - Per-namespace persistence, set by two paths
// RQ3 - Broadcast set updates all reservation namespaces
// RQ4 - Single-namespace set updates only that one
// RQ5 - Get returns that namespace's persistence state
// RQ6 - Unsupported namespace aborts with invalid field
// RQ7 - Get success puts attribute in dword 0
// RQ8 - Bit 0 one keeps reservations over power loss
// RQ9 - Bit 0 zero releases reservations on loss
// RQ10 - Post completion after attribute update
// RQ11 - Status 0Dh when feature not saveable
// RQ12 - Status 0Eh when feature not changeable
// RQ13 - Status 0Fh when feature not namespace specific
// RQ14 - Format uses only dword 10 low bits
// RQ15 - Broadcast format covers every namespace
// RQ16 - Format fails in invalid security state
// RQ17 - Applied format reported per namespace
// RQ18 - Secure erase covers all user data
// RQ19 - Crypto erase deletes the content key
// RQ20 - Erase select codes none, user, crypto
// RQ21 - Placement bit puts protection first or last
// RQ22 - Protection type codes disabled and types 1-3
// RQ23 - Reserved format codes abort invalid field
// RQ24 - Reserved attribute bits ignored, read zero
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module pfdec_core
  import pfdec_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power loss pin
  input wire logic power_loss,
  // Completion queue posting
  output logic cq_post,
  output logic [31:0] cq_dw0,
  output logic [10:0] cq_status,
  // Format and erase requests to the media engine
  output logic fmt_start,
  output logic [NS_COUNT-1:0] fmt_ns_mask,
  output logic [2:0] erase_sel,
  output logic [2:0] pi_type,
  output logic pi_first,
  output logic key_delete,
  // Reservation release on power loss
  output logic [NS_COUNT-1:0] resv_release
);
  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic ns_ok(input logic [31:0] id);
    ns_ok = (id != 32'h0) && (id <= 32'(NS_COUNT));
  endfunction

  function automatic logic [NS_BITS-1:0] ns_idx(input logic [31:0] id);
    logic [31:0] t;
    t = id - 32'h1;
    ns_idx = t[NS_BITS-1:0];
  endfunction

  pfdec_state_t q;
  pfdec_state_t n;

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input pfdec_state_t s);
    reg_read = 32'h0;
    unique case (a)
      OFS_CMD: reg_read = {30'h0, s.cmd};
      OFS_NSID: reg_read = s.nsid;
      OFS_DW10: reg_read = s.dw10;
      OFS_DW11: reg_read = s.dw11;
      OFS_STATUS: reg_read = {16'h0, s.sc, 3'h0, s.sct, s.st == PFD_EXEC,
                              s.done};
      OFS_CPL_DW0: reg_read = s.dw0;
      OFS_RESV_CAP: reg_read = {24'h0, s.cap};
      OFS_PERSIST: reg_read = {24'h0, s.persist};
      OFS_FMT_SEL: reg_read = {29'h0, s.fmt_sel};
      OFS_FMT_INFO: reg_read = {20'h0, s.fmt[s.fmt_sel]};
      OFS_SEC_STATE: reg_read = {31'h0, s.sec_bad};
      default: reg_read = 32'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic bcast;
    logic nok;
    logic hit;
    logic [NS_BITS-1:0] idx;
    logic [7:0] fid;
    logic [2:0] esel;
    logic [2:0] ptype;
    logic [NS_COUNT-1:0] mask;
    logic [NS_COUNT-1:0] upd;
    bcast = q.nsid == NSID_BROADCAST;
    nok = ns_ok(q.nsid);
    idx = ns_idx(q.nsid);
    hit = nok && q.cap[idx];
    fid = q.dw10[FID_LSB +: 8];
    esel = q.dw10[ERASE_SEL_LSB +: 3];
    ptype = q.dw10[PROT_TYPE_LSB +: 3];
    mask = '0;
    upd = '0;
    n = q;
    n.cq_post = 1'b0;
    n.fmt_start = 1'b0;
    n.key_delete = 1'b0;
    n.release_mask = '0;
    // Power loss pin synchroniser and edge
    n.pl_s1 = power_loss;
    n.pl_s2 = q.pl_s1;
    n.pl_d = q.pl_s2;
    if (q.pl_s2 && !q.pl_d) begin
      n.release_mask = q.cap & ~q.persist; // RQ9 RQ8
    end
    // Address phase: latch target, prepare read data
    n.dwr = hsel && hready && htrans[1] && hwrite;
    n.daddr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      n.rdata = (haddr[31:8] == 24'h0) ? reg_read(haddr[7:0], q) : 32'h0;
    end
    // Data phase: register writes
    if (q.dwr) begin
      unique case (q.daddr)
        OFS_CMD: begin
          if (q.st == PFD_IDLE) begin
            n.cmd = pfdec_cmd_t'(hwdata[1:0]);
            n.st = PFD_EXEC;
            n.done = 1'b0;
          end
        end
        OFS_NSID: n.nsid = hwdata;
        OFS_DW10: n.dw10 = hwdata;
        OFS_DW11: n.dw11 = hwdata;
        OFS_RESV_CAP: n.cap = hwdata[NS_COUNT-1:0];
        OFS_PERSIST: begin
          upd = hwdata[PERSIST_UPD_MASK_LSB +: NS_COUNT] & q.cap;
          n.persist = (q.persist & ~upd) |
                      (upd & {NS_COUNT{hwdata[PERSIST_BIT]}}); // RQ2
        end
        OFS_FMT_SEL: n.fmt_sel = hwdata[NS_BITS-1:0];
        OFS_SEC_STATE: n.sec_bad = hwdata[0];
        default: ;
      endcase
    end
    // Command execution, one cycle
    if (q.st == PFD_EXEC) begin
      n.sct = SCT_GENERIC;
      n.sc = SC_SUCCESS;
      n.dw0 = 32'h0;
      unique case (q.cmd)
        PFD_CMD_SET: begin
          if (fid != FID_RESV_PERSIST) begin
            n.sct = SCT_CMD_SPEC;
            if (nok) begin
              n.sc = SC_NOT_NS_SPECIFIC; // RQ13
            end else begin
              n.sc = SC_NOT_CHANGEABLE; // RQ12
            end
          end else if (q.dw10[SAVE_BIT]) begin
            n.sct = SCT_CMD_SPEC;
            n.sc = SC_NOT_SAVEABLE; // RQ11
          end else if (bcast) begin
            n.persist = (q.persist & ~q.cap) |
                        (q.cap & {NS_COUNT{q.dw11[PERSIST_BIT]}}); // RQ3 RQ1
          end else if (hit) begin
            n.persist[idx] = q.dw11[PERSIST_BIT]; // RQ4 RQ24
          end else begin
            n.sc = SC_INVALID_FIELD; // RQ6
          end
        end
        PFD_CMD_GET: begin
          if (fid == FID_RESV_PERSIST && !bcast && hit) begin
            n.dw0 = {31'h0, q.persist[idx]}; // RQ5 RQ7 RQ24
          end else begin
            n.sc = SC_INVALID_FIELD; // RQ6
          end
        end
        PFD_CMD_FORMAT: begin
          // Only dword 10 bits 11:0 are decoded
          if (bcast) begin
            mask = '1; // RQ15
          end else if (nok) begin
            mask[idx] = 1'b1; // RQ14
          end
          if (q.sec_bad) begin
            n.sc = SC_SEC_STATE; // RQ16
          end else if (mask == '0) begin
            n.sc = SC_INVALID_FIELD;
          end else if (esel > ERASE_CRYPTO || ptype > PROT_TYPE3) begin
            n.sc = SC_INVALID_FIELD; // RQ23 RQ20 RQ22
          end else begin
            for (int i = 0; i < NS_COUNT; i++) begin
              if (mask[i]) begin
                n.fmt[i] = q.dw10[FMT_LSB +: FMT_W]; // RQ17
              end
            end
            // Erase applies to all media of each namespace in the mask
            n.fmt_start = 1'b1; // RQ18
            n.fmt_mask = mask;
            n.erase_sel = esel; // RQ20
            n.pi_type = ptype; // RQ22
            n.pi_first = (ptype != PROT_OFF) && q.dw10[PROT_FIRST_BIT]; // RQ21
            n.key_delete = esel == ERASE_CRYPTO; // RQ19
          end
        end
        default: begin
          n.sc = SC_INVALID_FIELD;
        end
      endcase
      n.cq_post = 1'b1; // RQ10
      n.done = 1'b1;
      n.st = PFD_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.cap <= RST_RESV_CAP;
      q.persist <= RST_PERSIST;
    end else begin
      q <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign cq_post = q.cq_post;
  assign cq_dw0 = q.dw0;
  assign cq_status = {q.sct, q.sc};
  assign fmt_start = q.fmt_start;
  assign fmt_ns_mask = q.fmt_mask;
  assign erase_sel = q.erase_sel;
  assign pi_type = q.pi_type;
  assign pi_first = q.pi_first;
  assign key_delete = q.key_delete;
  assign resv_release = q.release_mask;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_post_after_go: assert property ( // RQ10
    q.dwr && q.daddr == OFS_CMD && q.st == PFD_IDLE |=> ##1 cq_post)
    else $error("no completion two cycles after launch");
  chk_get_dword0: assert property ( // RQ7
    q.st == PFD_EXEC && q.cmd == PFD_CMD_GET && n.sc == SC_SUCCESS
    |=> cq_dw0 == {31'h0, $past(q.persist[ns_idx(q.nsid)])})
    else $error("get completion dword 0 wrong");
  chk_not_saveable: assert property ( // RQ11
    q.st == PFD_EXEC && q.cmd == PFD_CMD_SET &&
    q.dw10[7:0] == FID_RESV_PERSIST && q.dw10[SAVE_BIT]
    |=> cq_status == {SCT_CMD_SPEC, SC_NOT_SAVEABLE} && cq_post)
    else $error("save request not refused with 0Dh");
  chk_not_changeable: assert property ( // RQ12
    q.st == PFD_EXEC && q.cmd == PFD_CMD_SET &&
    q.dw10[7:0] != FID_RESV_PERSIST && !ns_ok(q.nsid)
    |=> cq_status == {SCT_CMD_SPEC, SC_NOT_CHANGEABLE})
    else $error("other feature not refused with 0Eh");
  chk_not_ns_specific: assert property ( // RQ13
    q.st == PFD_EXEC && q.cmd == PFD_CMD_SET &&
    q.dw10[7:0] != FID_RESV_PERSIST && ns_ok(q.nsid)
    |=> cq_status == {SCT_CMD_SPEC, SC_NOT_NS_SPECIFIC})
    else $error("namespace on global feature not refused with 0Fh");
  chk_bcast_set: assert property ( // RQ3
    q.st == PFD_EXEC && q.cmd == PFD_CMD_SET && q.nsid == NSID_BROADCAST &&
    q.dw10[7:0] == FID_RESV_PERSIST && !q.dw10[SAVE_BIT]
    |=> q.persist == (($past(q.persist) & ~$past(q.cap)) |
        ($past(q.cap) & {NS_COUNT{$past(q.dw11[0])}})))
    else $error("broadcast set did not reach every namespace");
  chk_sec_fail: assert property ( // RQ16
    q.st == PFD_EXEC && q.cmd == PFD_CMD_FORMAT && q.sec_bad
    |=> !fmt_start && cq_status[7:0] == SC_SEC_STATE)
    else $error("format ran in invalid security state");
  chk_reserved_code: assert property ( // RQ23
    q.st == PFD_EXEC && q.cmd == PFD_CMD_FORMAT &&
    (q.dw10[11:9] > ERASE_CRYPTO || q.dw10[7:5] > PROT_TYPE3)
    |=> !fmt_start && cq_status[7:0] != SC_SUCCESS)
    else $error("reserved format code accepted");
  chk_power_release: assert property ( // RQ9
    q.pl_s2 && !q.pl_d
    |=> resv_release == ($past(q.cap) & ~$past(q.persist)))
    else $error("power loss release mask wrong");
  chk_crypto_key: assert property ( // RQ19
    fmt_start |-> key_delete == (erase_sel == ERASE_CRYPTO))
    else $error("key delete not tied to crypto erase");

  cov_get_ok: cover property (
    cq_post && cq_status == 11'h0 && $past(q.cmd) == PFD_CMD_GET);
  cov_bcast_format: cover property (fmt_start && fmt_ns_mask == '1);
  cov_release: cover property (resv_release != '0);
endmodule // pfdec_core

// [verif/pfdec_power_model.sv]
// Supply monitor model that pulses the power-fail pin high on request
`timescale 1ns/1ps
module pfdec_power_model (
  // Clock
  input wire logic hclk,
  // Power fail pin
  output logic power_loss
);
  initial power_loss = 1'b0;
  // Hold the fail level long enough for the two-stage sync
  task automatic drop(input int n);
    power_loss <= 1'b1;
    repeat (n) @(posedge hclk);
    power_loss <= 1'b0;
  endtask
endmodule // pfdec_power_model

// [verif/pfdec_core_tb.sv]
// Self-checking bench for the persistence and format decoder
`timescale 1ns/1ps
module pfdec_core_tb;
  import pfdec_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, power_loss, cq_post, fmt_start, pi_first, key_delete;
  logic [31:0] hrdata, cq_dw0, rd, r, ed;
  logic [10:0] cq_status, es;
  logic [7:0] fmt_ns_mask, resv_release;
  logic [2:0] erase_sel, pi_type, esel, ptype;
  logic [15:0] fe, mk;
  logic v;
  logic [43:0] cq_q[$];
  logic [15:0] fq[$];
  logic [7:0] rq[$];
  logic [31:0] bad[4] = '{32'h600, 32'hE00, 32'h80, 32'hE0};
  int miscompares = 0;
  int total_checks = 0;
  integer seed = 61;

  always #5 hclk = ~hclk;

  pfdec_core i_pfdec_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .power_loss(power_loss), .cq_post(cq_post),
    .cq_dw0(cq_dw0), .cq_status(cq_status), .fmt_start(fmt_start),
    .fmt_ns_mask(fmt_ns_mask), .erase_sel(erase_sel), .pi_type(pi_type),
    .pi_first(pi_first), .key_delete(key_delete),
    .resv_release(resv_release));
  pfdec_power_model i_pfdec_power_model (.hclk(hclk),
    .power_loss(power_loss));

  // ---------------------------------------------------------------
  // Bus and command tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  function automatic logic [43:0] ex(input logic [10:0] s, input logic c,
                                     input logic [31:0] d);
    return {c, s, d};
  endfunction

  task automatic cmd(input logic [1:0] c, input logic [31:0] ns, d10, d11,
                     input logic [43:0] e);
    int i;
    bus(1'b1, OFS_NSID, ns);
    bus(1'b1, OFS_DW10, d10);
    bus(1'b1, OFS_DW11, d11);
    cq_q.push_back(e);
    bus(1'b1, OFS_CMD, {30'h0, c});
    i = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && i < 20) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      i++;
    end
    chk("done", 32'h1, {31'h0, rd[0]});
  endtask

  task automatic fmt(input logic [31:0] ns, d10, input logic [10:0] s);
    if (s === 11'h0)
      fq.push_back({ns == NSID_BROADCAST ? 8'hFF : 8'(8'h1 << (ns - 1)),
        d10[11:9], d10[7:5], d10[8], d10[11:9] == ERASE_CRYPTO});
    cmd(PFD_CMD_FORMAT, ns, d10, $random(seed), {1'b0, s, 32'h0});
  endtask

  task automatic test_done;
    if (cq_q.size() + fq.size() + rq.size() != 0) chk("pending", 0, 1);
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  always @(negedge hclk) begin
    if (cq_post === 1'b1) begin
      if (cq_q.size() == 0) chk("cq_extra", 0, 1);
      else begin
        {v, es, ed} = cq_q.pop_front();
        chk("cq_status", {21'h0, es}, {21'h0, cq_status});
        if (v) chk("cq_dw0", ed, cq_dw0);
      end
    end
    if (fmt_start === 1'b1) begin
      if (fq.size() == 0) chk("fmt_extra", 0, 1);
      else begin
        fe = fq.pop_front();
        mk = (fe[4:2] == PROT_OFF) ? 16'hFFFD : 16'hFFFF;
        chk("fmt", {16'h0, fe & mk}, {16'h0, mk & {fmt_ns_mask,
          erase_sel, pi_type, pi_first, key_delete}});
      end
    end
    if (resv_release !== 8'h0) begin
      if (rq.size() == 0) chk("release_extra", 0, 1);
      else chk("release", {24'h0, rq.pop_front()}, {24'h0, resv_release});
    end
  end

  initial begin
    #200000;
    miscompares++;
    test_done;
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("cap", OFS_RESV_CAP, 32'h0F);
    rdc("persist", OFS_PERSIST, 32'h0);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rdc("unmapped", 8'h3C, 32'h0);
    cmd(PFD_CMD_SET, NSID_BROADCAST, 32'h83, $random(seed) | 1, ex(0, 0, 0));
    rdc("persist", OFS_PERSIST, 32'h0F);
    cmd(PFD_CMD_GET, 32'h2, 32'h83, 32'h0, ex(0, 1, 1));
    cmd(PFD_CMD_SET, 32'h3, 32'h83, $random(seed) & ~1, ex(0, 0, 0));
    rdc("persist", OFS_PERSIST, 32'h0B);
    cmd(PFD_CMD_GET, 32'h3, 32'h83, 32'h0, ex(0, 1, 0));
    cmd(PFD_CMD_SET, 32'h6, 32'h83, 32'h1, ex(11'h002, 0, 0));
    cmd(PFD_CMD_GET, 32'h6, 32'h83, 32'h0, ex(11'h002, 0, 0));
    cmd(PFD_CMD_GET, NSID_BROADCAST, 32'h83, 32'h0, ex(11'h002, 0, 0));
    cmd(PFD_CMD_NONE, 32'h1, 32'h83, 32'h0, ex(11'h002, 0, 0));
    cmd(PFD_CMD_SET, 32'h1, 32'h80000083, 32'h0, ex(11'h10D, 0, 0));
    cmd(PFD_CMD_SET, NSID_BROADCAST, 32'h05, 32'h0, ex(11'h10E, 0, 0));
    cmd(PFD_CMD_SET, 32'h1, 32'h05, 32'h0, ex(11'h10F, 0, 0));
    rdc("persist", OFS_PERSIST, 32'h0B);
    bus(1'b1, OFS_PERSIST, 32'h00001900);
    rdc("persist", OFS_PERSIST, 32'h02);
    bus(1'b1, OFS_PERSIST, 32'h00003101);
    rdc("persist", OFS_PERSIST, 32'h03);
    rq.push_back(8'h0C);
    i_pfdec_power_model.drop(4);
    repeat (8) @(posedge hclk);
    rdc("persist", OFS_PERSIST, 32'h03);
    bus(1'b1, OFS_SEC_STATE, 32'h1);
    fmt(NSID_BROADCAST, 32'h0, 11'h00C);
    bus(1'b1, OFS_SEC_STATE, 32'h0);
    fmt(32'h9, 32'h0, 11'h002);
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      esel = 3'(k / 4);
      ptype = 3'(k % 4);
      r[11:9] = esel;
      r[7:5] = ptype;
      fmt((k % 3 == 0) ? NSID_BROADCAST : 32'(k % 8 + 1), r, 11'h0);
      bus(1'b1, OFS_FMT_SEL, 32'(k % 8));
      rdc("fmt_info", OFS_FMT_INFO, {20'h0, r[11:0]});
    end
    foreach (bad[j]) fmt(32'h1, bad[j], 11'h002);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("persist", OFS_PERSIST, 32'h0);
    rdc("cap", OFS_RESV_CAP, 32'h0F);
    repeat (4) @(posedge hclk);
    test_done;
  end
endmodule // pfdec_core_tb
